// ==== hw/cdc_decoder.sv ====
// Purpose: decode the cyclic command image into state and mode actions
// Assumes: one request at most per cycle, answered on the next cycle
// Notes: status image and transport stay outside this block
`timescale 1ns/1ps
`default_nettype none

module cdc_decoder
  import cdc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register access
  input wire cdc_pkg::cdc_req_s req,
  output cdc_pkg::cdc_rsp_s rsp,
  // drive side
  input wire logic fault_event,
  input wire logic [1:0] error_class,
  output logic [3:0] state_code,
  output logic power_enable,
  output logic halt_active,
  output logic halt_resume_pulse,
  output logic mode_reject_flag,
  output logic mode_start_pulse,
  output logic [6:0] active_mode,
  output cdc_pkg::cdc_ref_s refs
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  cdc_image_s image;
  logic written;
  logic [7:0] prev_state_cmd;
  logic prev_toggle;
  cdc_state_e state;
  cdc_state_e next_state;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic hit_image = req.addr == CDC_IMAGE_ADDR &&
    (req.words == CDC_IMAGE_WORDS || req.words == CDC_PARAM_WORDS);
  wire logic hit_long = req.addr == CDC_LONG_ADDR &&
    req.words == CDC_PARAM_WORDS;
  wire logic hit_any = hit_image || hit_long;
  wire logic wr_ok = req.wr && hit_any;
  wire logic cmd_wr = req.wr && hit_image;
  wire logic full_wr = cmd_wr && req.words == CDC_IMAGE_WORDS;
  wire cdc_image_s wimg = req.wdata;

  // low part of an image write; long word on full image writes and long-register writes
  wire cdc_image_s next_image = '{
    long_ref: full_wr ? wimg.long_ref :
      (hit_long ? req.wdata[31:0] : image.long_ref),
    short_ref: cmd_wr ? wimg.short_ref : image.short_ref,
    mode_command_byte: cmd_wr ? wimg.mode_command_byte
      : image.mode_command_byte,
    state_command_byte: cmd_wr ? wimg.state_command_byte
      : image.state_command_byte
  };

  wire logic [63:0] rd_image = written ? image : CDC_IMAGE_RESET;
  wire logic [63:0] rd_word = hit_long ? {32'h0, rd_image[63:32]} :
    (req.words == CDC_IMAGE_WORDS ? rd_image : {32'h0, rd_image[31:0]});

  // ----------------------------------------------------------------
  // state-command edges and priorities
  // ----------------------------------------------------------------
  wire logic [7:0] sc = wimg.state_command_byte;
  wire logic [7:0] rise = sc & ~prev_state_cmd;
  wire logic req_off = cmd_wr && (rise[CDC_BIT_OFF] || sc == 8'h00);
  // bit 0 over bit 1, bit 2 over bit 3
  wire logic req_on = cmd_wr && rise[CDC_BIT_ON] && !rise[CDC_BIT_OFF];
  wire logic req_qs = cmd_wr && rise[CDC_BIT_QSTOP];
  // hard errors need bit 1 low
  wire logic fclr_allowed = error_class < CDC_CLASS_HARD ||
    !sc[CDC_BIT_ON];
  wire logic req_fr = cmd_wr && rise[CDC_BIT_FCLR] &&
    !rise[CDC_BIT_QSTOP] && fclr_allowed;
  // halt set over clear and resume
  wire logic req_hset = cmd_wr && rise[CDC_BIT_HSET];
  wire logic req_hclr = cmd_wr && rise[CDC_BIT_HCLR] &&
    !rise[CDC_BIT_HSET];
  wire logic req_hres = cmd_wr && rise[CDC_BIT_HRES] &&
    !rise[CDC_BIT_HSET];
  wire logic in_enabled = state == CDC_ST_ENABLED;

  // transitions; impossible ones leave state alone
  always_comb begin
    next_state = state;
    case (state)
      CDC_ST_READY: begin
        if (req_on && !req_off) begin
          next_state = CDC_ST_ENABLED;
        end
      end
      CDC_ST_ENABLED: begin
        if (req_off) begin
          next_state = CDC_ST_READY;
        end else if (req_qs) begin
          next_state = CDC_ST_QSTOP;
        end
      end
      CDC_ST_QSTOP: begin
        if (req_off) begin
          next_state = CDC_ST_READY;
        end else if (req_fr) begin
          next_state = CDC_ST_ENABLED;
        end
      end
      CDC_ST_FAULT: begin
        if (req_fr) begin
          next_state = CDC_ST_READY;
        end
      end
      default: next_state = CDC_ST_READY;
    endcase
    if (fault_event) begin
      next_state = CDC_ST_FAULT;
    end
  end

  // ----------------------------------------------------------------
  // mode-command decode
  // ----------------------------------------------------------------
  wire logic [7:0] mc = wimg.mode_command_byte;
  wire logic [6:0] mc_code = mc[6:0];
  wire logic [15:0] sref = wimg.short_ref;
  wire logic [31:0] lref = full_wr ? wimg.long_ref : image.long_ref;
  wire logic mc_valid = mc_code == CDC_MC_JOG ||
    mc_code == CDC_MC_HOME_SET || mc_code == CDC_MC_HOME_RUN ||
    mc_code == CDC_MC_PP_ABS || mc_code == CDC_MC_PP_RTGT ||
    mc_code == CDC_MC_PP_RACT || mc_code == CDC_MC_PV ||
    mc_code == CDC_MC_SPEED;
  wire logic mc_live = cmd_wr && mc != 8'h00;
  wire logic toggled = mc_live && mc[CDC_BIT_TOGGLE] != prev_toggle;
  wire logic mode_go = toggled && mc_valid && in_enabled &&
    next_state == CDC_ST_ENABLED;
  wire logic mode_bad = toggled && !mode_go;

  cdc_ref_s next_refs;
  always_comb begin
    next_refs = refs;
    case (mc_code)
      CDC_MC_JOG: next_refs.jog_start_value = sref;
      CDC_MC_HOME_SET: next_refs.home_position_value = lref;
      CDC_MC_HOME_RUN: next_refs.homing_method_value = sref;
      CDC_MC_PP_ABS: begin
        next_refs.profile_position_velocity = sref;
        next_refs.absolute_target_position = lref;
      end
      CDC_MC_PP_RTGT, CDC_MC_PP_RACT: begin
        next_refs.profile_position_velocity = sref;
        next_refs.relative_target_position = lref;
      end
      CDC_MC_PV: next_refs.profile_velocity_target = sref;
      CDC_MC_SPEED: next_refs.speed_control_reference = sref;
      default: next_refs = refs;
    endcase
  end

  wire logic [3:0] next_code = next_state == CDC_ST_ENABLED ?
    CDC_CODE_ENABLED : next_state == CDC_ST_QSTOP ? CDC_CODE_QSTOP :
    next_state == CDC_ST_FAULT ? CDC_CODE_FAULT : CDC_CODE_READY;
  wire logic next_halt = next_state == CDC_ST_ENABLED &&
    (in_enabled && req_hset ? 1'b1 :
     in_enabled && (req_hclr || req_hres) ? 1'b0 : halt_active);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      image <= CDC_IMAGE_RESET;
      written <= 1'b0;
      rsp <= '0;
    end else begin
      if (wr_ok) begin
        image <= next_image;
        written <= 1'b1;
      end
      rsp.valid <= req.wr || req.rd;
      // unmapped address or unsupported word count is the only error
      rsp.err <= (req.wr || req.rd) && !hit_any;
      rsp.rdata <= req.rd && hit_any ? rd_word : 64'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      prev_state_cmd <= 8'h00;
      prev_toggle <= 1'b0;
    end else if (cmd_wr) begin
      prev_state_cmd <= sc;
      prev_toggle <= mc[CDC_BIT_TOGGLE];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state <= CDC_ST_READY;
      state_code <= CDC_CODE_READY;
      power_enable <= 1'b0;
      halt_active <= 1'b0;
      halt_resume_pulse <= 1'b0;
    end else begin
      state <= next_state;
      state_code <= next_code;
      power_enable <= next_state == CDC_ST_ENABLED ||
        next_state == CDC_ST_QSTOP;
      halt_active <= next_halt;
      halt_resume_pulse <= in_enabled && req_hres &&
        next_state == CDC_ST_ENABLED;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mode_reject_flag <= 1'b0;
      mode_start_pulse <= 1'b0;
      active_mode <= 7'h00;
      refs <= '0;
    end else begin
      mode_start_pulse <= mode_go;
      // set on reject, cleared by next accepted toggle
      if (mode_bad) begin
        mode_reject_flag <= 1'b1;
      end else if (mode_go) begin
        mode_reject_flag <= 1'b0;
      end
      if (mode_go) begin
        active_mode <= mc_code;
        refs <= next_refs;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_read_before_write:
    assert property (!written && req.rd |=> rsp.rdata == 64'h0)
    else $error("image read nonzero before first write");

  a_enable_edge:
    assert property (state == CDC_ST_READY && req_on && !req_off &&
      !fault_event |=> state_code == CDC_CODE_ENABLED && power_enable)
    else $error("enable request did not reach enabled state");

  a_quick_stop:
    assert property (in_enabled && req_qs && !req_off && !fault_event
      |=> state_code == CDC_CODE_QSTOP)
    else $error("quick stop request not taken");

  a_level_no_act:
    assert property (cmd_wr && sc == prev_state_cmd && sc != 8'h00 &&
      !fault_event |=> $stable(state))
    else $error("steady request level changed state");

  a_zero_disables:
    assert property (cmd_wr && sc == 8'h00 && !fault_event &&
      state != CDC_ST_FAULT |=> state_code == CDC_CODE_READY && !power_enable)
    else $error("all-zero state byte left power stage on");

  a_hard_fault_hold:
    assert property (state == CDC_ST_FAULT && error_class >= CDC_CLASS_HARD
      && sc[CDC_BIT_ON] |=> state_code == CDC_CODE_FAULT)
    else $error("fault reset taken while enable bit high");

  a_zero_mode_skip:
    assert property (cmd_wr && mc == 8'h00 |=> !mode_start_pulse &&
      $stable(mode_reject_flag) && $stable(refs))
    else $error("zero mode byte was processed");

  a_no_toggle_hold:
    assert property (cmd_wr && mc[CDC_BIT_TOGGLE] == prev_toggle
      |=> !mode_start_pulse)
    else $error("mode started without toggle");

  a_reject_flag:
    assert property (mode_bad |=> mode_reject_flag && !mode_start_pulse)
    else $error("rejected mode request not flagged");

  a_halt_priority:
    assert property (in_enabled && req_hset && !req_off && !req_qs &&
      !fault_event |=> halt_active && !halt_resume_pulse)
    else $error("halt set lost against clear or resume");

  a_power_off:
    assert property (in_enabled && req_off && !fault_event |=>
      state_code == CDC_CODE_READY && !power_enable)
    else $error("power-off request did not reach ready state");

  a_fault_clear:
    assert property (state == CDC_ST_FAULT && req_fr && !fault_event |=>
      state_code == CDC_CODE_READY)
    else $error("fault reset did not reach ready state");

  a_mode_start:
    assert property (mode_go |=> mode_start_pulse &&
      active_mode == $past(mc_code))
    else $error("accepted mode toggle did not start mode");

  a_halt_scope:
    assert property (halt_active |-> state_code == CDC_CODE_ENABLED)
    else $error("halt active outside enabled state");

endmodule
`default_nettype wire

// ==== hw/cdc_pkg.sv ====
// Purpose: constants and carriers for the cyclic drive command decoder
// Assumes: one 40 MHz clock, transfers already unpacked from the network
// Notes: register addresses are 16-bit register numbers, not byte offsets
package cdc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [15:0] CDC_IMAGE_ADDR = 16'h1B0A;
  localparam logic [15:0] CDC_LONG_ADDR = 16'h1B0C;
  localparam logic [2:0] CDC_IMAGE_WORDS = 3'h4;
  localparam logic [2:0] CDC_PARAM_WORDS = 3'h2;
  localparam logic [63:0] CDC_IMAGE_RESET = 64'h0;
  // ----------------------------------------------------------------
  // state-command bit positions and the mode-command toggle bit
  // ----------------------------------------------------------------
  localparam int CDC_BIT_OFF = 0;
  localparam int CDC_BIT_ON = 1;
  localparam int CDC_BIT_QSTOP = 2;
  localparam int CDC_BIT_FCLR = 3;
  localparam int CDC_BIT_HSET = 5;
  localparam int CDC_BIT_HCLR = 6;
  localparam int CDC_BIT_HRES = 7;
  localparam int CDC_BIT_TOGGLE = 7;
  // ----------------------------------------------------------------
  // operating state codes and error class limit
  // ----------------------------------------------------------------
  localparam logic [3:0] CDC_CODE_READY = 4'h4;
  localparam logic [3:0] CDC_CODE_ENABLED = 4'h6;
  localparam logic [3:0] CDC_CODE_QSTOP = 4'h7;
  localparam logic [3:0] CDC_CODE_FAULT = 4'h9;
  localparam logic [1:0] CDC_CLASS_HARD = 2'h2;
  // ----------------------------------------------------------------
  // mode-command byte codes (toggle bit masked)
  // ----------------------------------------------------------------
  localparam logic [6:0] CDC_MC_JOG = 7'h01;
  localparam logic [6:0] CDC_MC_HOME_SET = 7'h02;
  localparam logic [6:0] CDC_MC_HOME_RUN = 7'h12;
  localparam logic [6:0] CDC_MC_PP_ABS = 7'h03;
  localparam logic [6:0] CDC_MC_PP_RTGT = 7'h13;
  localparam logic [6:0] CDC_MC_PP_RACT = 7'h23;
  localparam logic [6:0] CDC_MC_PV = 7'h04;
  localparam logic [6:0] CDC_MC_SPEED = 7'h17;

  typedef enum logic [1:0] {
    CDC_ST_READY,
    CDC_ST_ENABLED,
    CDC_ST_QSTOP,
    CDC_ST_FAULT
  } cdc_state_e;

  typedef struct packed {
    logic [31:0] long_ref;
    logic [15:0] short_ref;
    logic [7:0] mode_command_byte;
    logic [7:0] state_command_byte;
  } cdc_image_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [2:0] words;
    logic [63:0] wdata;
  } cdc_req_s;

  typedef struct packed {
    logic valid;
    logic err;
    logic [63:0] rdata;
  } cdc_rsp_s;

  typedef struct packed {
    logic [15:0] jog_start_value;
    logic [31:0] home_position_value;
    logic [15:0] homing_method_value;
    logic [15:0] profile_position_velocity;
    logic [31:0] absolute_target_position;
    logic [31:0] relative_target_position;
    logic [15:0] profile_velocity_target;
    logic [15:0] speed_control_reference;
  } cdc_ref_s;
endpackage

// ==== verification/cdc_master_model.sv ====
// Purpose: cyclic scanning master model for the command decoder
// Assumes: requests launched and released at falling edges
// Notes: released address and data show inverted values; word count keeps the old one
`timescale 1ns/1ps
`default_nettype none
module cdc_master_model
  import cdc_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // register access
  output var cdc_pkg::cdc_req_s req,
  input wire cdc_pkg::cdc_rsp_s rsp
);
  initial begin
    req = '0;
  end

  task automatic xfer(input logic wr, input logic [15:0] addr,
    input logic [2:0] words, input logic [63:0] wdata,
    output cdc_rsp_s r);
    @(negedge ref_clk);
    req.wr = wr;
    req.rd = ~wr;
    req.addr = addr;
    req.words = words;
    req.wdata = wdata;
    @(negedge ref_clk);
    r = rsp;
    req.wr = 1'b0;
    req.rd = 1'b0;
    req.addr = ~addr;
    req.wdata = ~wdata;
  endtask
endmodule
`default_nettype wire

// ==== verification/cyclic_drive_command_decoder_bench.sv ====
// Purpose: self-checking bench for the cyclic drive command decoder
// Assumes: inputs change at falling edges, 40 MHz clock
// Notes: every register access goes through the master model
`timescale 1ns/1ps
`default_nettype none
module cyclic_drive_command_decoder_bench;
  import cdc_pkg::*;
  localparam logic [6:0] MCODE [8] = '{CDC_MC_JOG, CDC_MC_HOME_SET,
    CDC_MC_HOME_RUN, CDC_MC_PP_ABS, CDC_MC_PP_RTGT, CDC_MC_PP_RACT,
    CDC_MC_PV, CDC_MC_SPEED};
  localparam logic [7:0] SH_USE = 8'hFD;
  localparam logic [7:0] LO_USE = 8'h3A;
  logic ref_clk;
  logic rstn;
  logic fault_event;
  logic [1:0] error_class;
  cdc_req_s req;
  cdc_rsp_s rsp;
  cdc_rsp_s r;
  logic [3:0] state_code;
  logic power_enable;
  logic halt_active;
  logic halt_resume_pulse;
  logic mode_reject_flag;
  logic mode_start_pulse;
  logic [6:0] active_mode;
  cdc_ref_s refs;
  int error_cnt;
  int samples_checked;

  cdc_decoder u_cdc_decoder (.ref_clk(ref_clk), .rstn(rstn), .req(req),
    .rsp(rsp), .fault_event(fault_event), .error_class(error_class),
    .state_code(state_code), .power_enable(power_enable),
    .halt_active(halt_active), .halt_resume_pulse(halt_resume_pulse),
    .mode_reject_flag(mode_reject_flag),
    .mode_start_pulse(mode_start_pulse), .active_mode(active_mode),
    .refs(refs));
  cdc_master_model u_cdc_master_model (.ref_clk(ref_clk), .req(req),
    .rsp(rsp));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // compare and access helpers
  // ----------------------------------------------------------------
  task automatic miss(input string what);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, what);
  endtask
  task automatic chk_s(input logic [3:0] exp, input string what);
    samples_checked++;
    if (state_code !== exp) miss(what);
  endtask
  task automatic chk_b(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) miss(what);
  endtask
  task automatic chk_v(input logic [63:0] got, input logic [63:0] exp,
    input string what);
    samples_checked++;
    if (got !== exp) miss(what);
  endtask
  task automatic wr_img(input logic [7:0] sc, input logic [7:0] mc,
    input logic [15:0] sr, input logic [31:0] lr);
    u_cdc_master_model.xfer(1'b1, CDC_IMAGE_ADDR, CDC_IMAGE_WORDS,
      {lr, sr, mc, sc}, r);
    chk_b(r.valid & ~r.err, 1'b1, "write ack");
  endtask
  task automatic sc_w(input logic [7:0] sc, input logic [3:0] st);
    wr_img(sc, 8'h00, 16'h0, 32'h0);
    chk_s(st, "state after write");
  endtask
  task automatic pulse_fault;
    @(negedge ref_clk);
    fault_event = 1'b1;
    @(negedge ref_clk);
    fault_event = 1'b0;
    chk_s(CDC_CODE_FAULT, "fault state");
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk_s(CDC_CODE_READY, "reset state");
    chk_b(power_enable, 1'b0, "reset power");
    u_cdc_master_model.xfer(1'b0, CDC_IMAGE_ADDR, CDC_IMAGE_WORDS, 64'h0, r);
    chk_v(r.rdata, 64'h0, "image before write");
    $display("test reset done");
  endtask
  task automatic t_power;
    sc_w(8'h02, CDC_CODE_ENABLED);
    chk_b(power_enable, 1'b1, "power on");
    sc_w(8'h01, CDC_CODE_READY);
    sc_w(8'h03, CDC_CODE_ENABLED);
    sc_w(8'h03, CDC_CODE_ENABLED);
    sc_w(8'h00, CDC_CODE_READY);
    sc_w(8'h03, CDC_CODE_READY);
    sc_w(8'h08, CDC_CODE_READY);
    $display("test power done");
  endtask
  task automatic t_qstop;
    sc_w(8'h02, CDC_CODE_ENABLED);
    sc_w(8'h06, CDC_CODE_QSTOP);
    chk_b(power_enable, 1'b1, "power in quick stop");
    sc_w(8'h0E, CDC_CODE_ENABLED);
    sc_w(8'h02, CDC_CODE_ENABLED);
    sc_w(8'h0E, CDC_CODE_QSTOP);
    sc_w(8'h01, CDC_CODE_READY);
    $display("test quick stop done");
  endtask
  task automatic t_halt;
    sc_w(8'h02, CDC_CODE_ENABLED);
    sc_w(8'h22, CDC_CODE_ENABLED);
    chk_b(halt_active, 1'b1, "halt set");
    sc_w(8'h62, CDC_CODE_ENABLED);
    chk_b(halt_active, 1'b0, "halt cleared");
    sc_w(8'h02, CDC_CODE_ENABLED);
    sc_w(8'h22, CDC_CODE_ENABLED);
    sc_w(8'hA2, CDC_CODE_ENABLED);
    chk_b(halt_resume_pulse, 1'b1, "resume pulse");
    chk_b(halt_active, 1'b0, "halt after resume");
    sc_w(8'h02, CDC_CODE_ENABLED);
    sc_w(8'hE2, CDC_CODE_ENABLED);
    chk_b(halt_active, 1'b1, "halt wins");
    chk_b(halt_resume_pulse, 1'b0, "no resume");
    sc_w(8'h01, CDC_CODE_READY);
    chk_b(halt_active, 1'b0, "halt off outside enabled");
    $display("test halt done");
  endtask
  task automatic t_fault;
    error_class = CDC_CLASS_HARD;
    pulse_fault();
    chk_b(power_enable, 1'b0, "power in fault");
    sc_w(8'h0A, CDC_CODE_FAULT);
    sc_w(8'h10, CDC_CODE_FAULT);
    sc_w(8'h18, CDC_CODE_READY);
    error_class = 2'h1;
    pulse_fault();
    sc_w(8'h10, CDC_CODE_FAULT);
    sc_w(8'h1A, CDC_CODE_READY);
    $display("test fault done");
  endtask
  task automatic t_mode;
    logic tgl;
    logic [15:0] sh;
    logic [15:0] gs;
    logic [31:0] lo;
    logic [31:0] gl;
    // bit 1 was left high by the fault test; drop it to get an edge
    sc_w(8'h00, CDC_CODE_READY);
    sc_w(8'h02, CDC_CODE_ENABLED);
    tgl = 1'b0;
    for (int i = 0; i < 8; i++) begin
      tgl = ~tgl;
      sh = SH_USE[i] ? {12'h100, 4'(i)} : 16'h0;
      lo = LO_USE[i] ? {28'hA000000, 4'(i)} : 32'h0;
      wr_img(8'h02, {tgl, MCODE[i]}, sh, lo);
      chk_b(mode_start_pulse, 1'b1, "mode start");
      chk_v(64'(active_mode), 64'(MCODE[i]), "mode code");
      gs = 16'h0;
      gl = 32'h0;
      case (i)
        0: gs = refs.jog_start_value;
        1: gl = refs.home_position_value;
        2: gs = refs.homing_method_value;
        3: {gs, gl} = {refs.profile_position_velocity,
          refs.absolute_target_position};
        4, 5: {gs, gl} = {refs.profile_position_velocity,
          refs.relative_target_position};
        6: gs = refs.profile_velocity_target;
        default: gs = refs.speed_control_reference;
      endcase
      chk_v({16'h0, gs, gl}, {16'h0, sh, lo}, "mode refs");
    end
    wr_img(8'h02, {tgl, CDC_MC_PV}, 16'h55, 32'h0);
    chk_b(mode_start_pulse, 1'b0, "no toggle no start");
    chk_v(64'(active_mode), 64'(CDC_MC_SPEED), "mode kept");
    wr_img(8'h02, 8'h00, 16'h77, 32'h0);
    chk_b(mode_start_pulse, 1'b0, "zero mode byte");
    chk_b(mode_reject_flag, 1'b0, "zero byte no error");
    wr_img(8'h02, 8'h85, 16'h0, 32'h0);
    chk_b(mode_reject_flag, 1'b1, "bad code rejected");
    chk_b(mode_start_pulse, 1'b0, "bad code no start");
    wr_img(8'h02, {1'b0, CDC_MC_PV}, 16'h0123, 32'h0);
    chk_b(mode_start_pulse, 1'b1, "start after reject");
    chk_b(mode_reject_flag, 1'b0, "reject cleared");
    chk_v(64'(refs.profile_velocity_target), 64'h0123, "pv ref");
    sc_w(8'h01, CDC_CODE_READY);
    $display("test mode done");
  endtask
  task automatic t_regs;
    u_cdc_master_model.xfer(1'b1, 16'h1B0E, CDC_IMAGE_WORDS, 64'h0, r);
    chk_b(r.valid & r.err, 1'b1, "unmapped address");
    u_cdc_master_model.xfer(1'b1, CDC_IMAGE_ADDR, 3'h3, 64'h0, r);
    chk_b(r.valid & r.err, 1'b1, "bad length");
    u_cdc_master_model.xfer(1'b1, CDC_LONG_ADDR, CDC_PARAM_WORDS,
      64'h1234_5678, r);
    chk_b(r.valid & ~r.err, 1'b1, "long write");
    chk_s(CDC_CODE_READY, "long write no command");
    u_cdc_master_model.xfer(1'b0, CDC_LONG_ADDR, CDC_PARAM_WORDS, 64'h0, r);
    chk_v(r.rdata, 64'h1234_5678, "long read");
    u_cdc_master_model.xfer(1'b0, CDC_IMAGE_ADDR, CDC_IMAGE_WORDS, 64'h0, r);
    chk_v(r.rdata, 64'h1234_5678_0000_0001, "image read");
    // two-word image write keeps the stored long word
    u_cdc_master_model.xfer(1'b1, CDC_IMAGE_ADDR, CDC_PARAM_WORDS,
      64'hFFFF_FFFF_5A5A_0001, r);
    chk_b(r.valid & ~r.err, 1'b1, "short image write");
    u_cdc_master_model.xfer(1'b0, CDC_IMAGE_ADDR, CDC_PARAM_WORDS, 64'h0, r);
    chk_v(r.rdata, 64'h5A5A_0001, "short image read");
    u_cdc_master_model.xfer(1'b0, CDC_IMAGE_ADDR, CDC_IMAGE_WORDS, 64'h0, r);
    chk_v(r.rdata, 64'h1234_5678_5A5A_0001, "long word kept");
    $display("test registers done");
  endtask
  task automatic t_rerst;
    sc_w(8'h02, CDC_CODE_ENABLED);
    @(negedge ref_clk);
    rstn = 1'b0;
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    chk_s(CDC_CODE_READY, "state after reset");
    chk_b(power_enable, 1'b0, "power after reset");
    u_cdc_master_model.xfer(1'b0, CDC_IMAGE_ADDR, CDC_IMAGE_WORDS, 64'h0, r);
    chk_v(r.rdata, 64'h0, "image after reset");
    $display("test mid-run reset done");
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    miss("watchdog expired");
    final_report();
  end
  initial begin
    rstn = 1'b0;
    fault_event = 1'b0;
    error_class = 2'h0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (8) @(negedge ref_clk);
    rstn = 1'b1;
    t_reset();
    t_power();
    t_qstop();
    t_halt();
    t_fault();
    t_mode();
    t_regs();
    t_rerst();
    final_report();
  end
endmodule
`default_nettype wire
